/* design/bwdt_consts.svh */
// constants for the board watchdog reset timer
`ifndef BWDT_CONSTS_SVH
`define BWDT_CONSTS_SVH
`define BWDT_CNT_W        24
`define BWDT_CNT_MAX      24'hffffff
`define BWDT_INIT_RST     24'hffffff
`define BWDT_CLK_HZ       20000000
`define BWDT_TICK_HZ      32768
`define BWDT_TICK_DIV     (`BWDT_CLK_HZ / `BWDT_TICK_HZ)
`define BWDT_TDIV_W       10
`define BWDT_PORT80_ADDR  16'h0080
`define BWDT_RST_CYCLES   8'h10
`endif

/* design/bwdt_pkg.sv */
// types for the board watchdog reset timer
package bwdt_pkg;
  typedef logic [23:0] bwdt_count_t;
  typedef logic [15:0] bwdt_addr_t;
  typedef logic [3:0]  bwdt_mask_t;
endpackage : bwdt_pkg

/* design/bwdt_top.sv */
// board watchdog reset timer: 24-bit countdown issuing system reset
`timescale 1ns/1ps
`default_nettype none
`include "bwdt_consts.svh"
module bwdt_top (
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  input  wire bwdt_pkg::bwdt_count_t i_init_value,
  input  wire logic             i_init_wr,
  input  wire logic             i_count_wr,
  input  wire logic             i_io_valid,
  input  wire logic             i_io_write,
  input  wire bwdt_pkg::bwdt_addr_t i_io_addr,
  input  wire logic             i_port80_en,
  input  wire logic             i_win_en,
  input  wire bwdt_pkg::bwdt_addr_t i_win1_base,
  input  wire bwdt_pkg::bwdt_addr_t i_win2_base,
  input  wire bwdt_pkg::bwdt_mask_t i_win1_mask,
  input  wire bwdt_pkg::bwdt_mask_t i_win2_mask,
  output logic                  o_sys_reset,
  output var bwdt_pkg::bwdt_count_t o_timeout_count_value,
  output var bwdt_pkg::bwdt_count_t o_init_value
);
  import bwdt_pkg::*;

  function automatic logic win_hit(input bwdt_addr_t a, input bwdt_addr_t b,
                                   input bwdt_mask_t m);
    win_hit = ((a[15:4] == b[15:4]) && ((a[3:0] & ~m) == (b[3:0] & ~m)));
  endfunction : win_hit

  bwdt_count_t            init_reg;
  bwdt_count_t            count_reg;
  bwdt_count_t            count_next;
  logic [`BWDT_TDIV_W-1:0] tdiv_reg;
  logic                   tick;
  logic                   expired_reg;
  logic [7:0]             rst_cnt_reg;

  // tick divider: 20 MHz / 610 gives about 32787 Hz, a 0.06% fast period
  assign tick = (tdiv_reg == `BWDT_TDIV_W'(`BWDT_TICK_DIV - 1));

  wire port80_hit = i_port80_en && i_io_valid && i_io_write
                    && (i_io_addr == `BWDT_PORT80_ADDR);
  wire win_strobe = i_win_en && i_io_valid
                    && (win_hit(i_io_addr, i_win1_base, i_win1_mask)
                        || win_hit(i_io_addr, i_win2_base, i_win2_mask));
  wire restart    = i_count_wr || port80_hit || win_strobe;
  wire at_zero    = (count_reg == 24'h000000);

  always_comb
  begin
    count_next = count_reg;
    if (restart)
      count_next = init_reg;
    else if (tick && !at_zero)
      count_next = count_reg - 24'h000001;
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      tdiv_reg <= '0;
    else if (tick)
      tdiv_reg <= '0;
    else
      tdiv_reg <= tdiv_reg + `BWDT_TDIV_W'(1);
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      init_reg  <= `BWDT_INIT_RST;
      count_reg <= `BWDT_INIT_RST;
    end
    else
    begin
      if (i_init_wr)
        init_reg <= i_init_value;
      count_reg <= count_next;
    end
  end

  // reset pulse is stretched so a board reset sees a clean width
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      expired_reg <= 1'b0;
      rst_cnt_reg <= 8'h00;
    end
    else if (at_zero && !restart && !expired_reg)
    begin
      expired_reg <= 1'b1;
      rst_cnt_reg <= `BWDT_RST_CYCLES;
    end
    else if (rst_cnt_reg != 8'h00)
      rst_cnt_reg <= rst_cnt_reg - 8'h01;
    else if (!at_zero)
      expired_reg <= 1'b0;
  end

  assign o_sys_reset           = (rst_cnt_reg != 8'h00);
  assign o_timeout_count_value = count_reg;
  assign o_init_value          = init_reg;

  AST_RESTART_RELOAD: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    restart
    |=> (count_reg == $past(init_reg)))
    else $error("no reload on restart");

  AST_COUNT_WR: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_count_wr
    |=> (count_reg == $past(init_reg)))
    else $error("count write did not reload");

  AST_PORT80: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_port80_en && i_io_valid && i_io_write && i_io_addr == 16'h0080)
    |=> (count_reg == $past(init_reg)))
    else $error("port 80h no restart");

  AST_WINDOW: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_win_en && i_io_valid && i_io_addr == i_win1_base)
    |=> (count_reg == $past(init_reg)))
    else $error("window hit no restart");

  AST_WINDOW2: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_win_en && i_io_valid && i_io_addr == i_win2_base)
    |=> (count_reg == $past(init_reg)))
    else $error("second window hit no restart");

  // the top address of a masked window must still hit
  AST_WIN_MASKED: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_win_en && i_io_valid && i_io_addr == (i_win1_base | 16'(i_win1_mask)))
    |=> (count_reg == $past(init_reg)))
    else $error("masked window hit no restart");

  AST_DECREMENT: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (tick && !restart && !at_zero)
    |=> (count_reg == $past(count_reg) - 24'h000001))
    else $error("count did not step down");

  AST_HOLD: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (!tick && !restart)
    |=> $stable(count_reg))
    else $error("count moved without tick");

  AST_TICK_GAP: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    tick
    |=> !tick [*8])
    else $error("ticks too close");

  AST_ZERO_STAYS: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (at_zero && !restart)
    |=> at_zero)
    else $error("count left zero without restart");

  AST_INIT_NO_RESTART: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_init_wr && !restart && !tick)
    |=> $stable(count_reg))
    else $error("period write moved the count");

  AST_EXPIRE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (at_zero && !restart && !expired_reg)
    |=> o_sys_reset [*8])
    else $error("expiry gave no reset");

  // the pulse is sixteen cycles wide, checked as two runs of eight
  AST_PULSE_WIDTH: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $rose(o_sys_reset)
    |-> o_sys_reset [*8] ##1 o_sys_reset [*8] ##1 !o_sys_reset)
    else $error("reset pulse width wrong");

  AST_ONE_PULSE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    ($fell(o_sys_reset) && !restart)
    |=> !o_sys_reset)
    else $error("second reset pulse for one expiry");

  AST_NEEDS_EXPIRY: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_sys_reset
    |-> expired_reg)
    else $error("reset without expiry");

  AST_NO_EARLY: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $rose(o_sys_reset)
    |-> $past(at_zero))
    else $error("reset before zero");

  AST_INIT_WR: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_init_wr
    |=> (init_reg == $past(i_init_value)))
    else $error("init not stored");

  AST_RESET_MAX: assert property (@(posedge i_mclk)
    !i_rst_n
    |=> (init_reg == 24'hffffff))
    else $error("reset period not max");

  AST_RESET_COUNT_MAX: assert property (@(posedge i_mclk)
    !i_rst_n
    |=> (count_reg == 24'hffffff))
    else $error("reset count not max");

  AST_RESET_QUIET: assert property (@(posedge i_mclk)
    !i_rst_n
    |=> !o_sys_reset)
    else $error("system reset during local reset");
endmodule : bwdt_top
`default_nettype wire

/* tb/bwdt_host.sv */
// host model: issues i/o port accesses toward the watchdog
`timescale 1ns/1ps
`default_nettype none
module bwdt_host (
  input  wire logic                 i_mclk,
  output var  logic                 o_valid,
  output var  logic                 o_write,
  output var  bwdt_pkg::bwdt_addr_t o_addr
);
  initial {o_valid, o_write, o_addr} = 18'h0;
  // released address is inverted so a stale value never looks valid
  task access(input bwdt_pkg::bwdt_addr_t a, input logic w);
    @(posedge i_mclk) {o_valid, o_write, o_addr} <= {1'b1, w, a};
    @(posedge i_mclk) {o_valid, o_addr} <= {1'b0, ~a};
  endtask : access
endmodule : bwdt_host
`default_nettype wire

/* tb/tb_bwdt_top.sv */
// self-checking bench for the board watchdog reset timer
`timescale 1ns/1ps
`default_nettype none
module tb_bwdt_top;
  import bwdt_pkg::*;
  logic        i_mclk = 0, i_rst_n = 0, i_init_wr = 0, i_count_wr = 0;
  logic        i_port80_en = 0, i_win_en = 0, v, w, o_sys_reset;
  bwdt_count_t i_init_value = 24'h0, o_tcv, o_iv;
  bwdt_addr_t  a;
  int          n_fail = 0, compares = 0, k;
  bwdt_top uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_init_value(i_init_value),
    .i_init_wr(i_init_wr), .i_count_wr(i_count_wr), .i_io_valid(v), .i_io_write(w),
    .i_io_addr(a), .i_port80_en(i_port80_en), .i_win_en(i_win_en),
    .i_win1_base(16'h0300), .i_win2_base(16'h0400), .i_win1_mask(4'h3),
    .i_win2_mask(4'h0), .o_sys_reset(o_sys_reset), .o_timeout_count_value(o_tcv),
    .o_init_value(o_iv));
  bwdt_host host (.i_mclk(i_mclk), .o_valid(v), .o_write(w), .o_addr(a));
  initial forever #25 i_mclk = ~i_mclk;
  task chk(input string nm, input bwdt_count_t e, input bwdt_count_t s);
    compares++;
    if (s !== e) $display("FAIL %s expected %h seen %h", nm, e, s);
    if (s !== e) n_fail++;
  endtask : chk
  task set_init(input bwdt_count_t x);
    @(posedge i_mclk) {i_init_value, i_init_wr} <= {x, 1'b1};
    @(posedge i_mclk) i_init_wr <= 0;
  endtask : set_init
  task test_expiry;
    set_init(24'h000002);
    @(posedge i_mclk) i_count_wr <= 1;
    @(posedge i_mclk) i_count_wr <= 0;
    #1 chk("restart", 24'h000002, o_tcv);
    chk("period set", 24'h000002, o_iv);
    k = 0;
    while (o_sys_reset !== 1'b1 && k < 1900) @(posedge i_mclk) #1 k++;
    chk("expiry time", 24'h1, {23'h0, k >= 610 && k <= 1225});
    repeat (15) @(posedge i_mclk);
    #1 chk("reset held", 24'h1, {23'h0, o_sys_reset});
    chk("count at zero", 24'h0, o_tcv);
    @(posedge i_mclk) #1 chk("reset ends", 24'h0, {23'h0, o_sys_reset});
    $display("test expiry done");
  endtask : test_expiry
  // flags per case: port80 enable, window enable, write, restart expected
  task test_strobes;
    bwdt_addr_t ad [6] = '{16'h0080, 16'h0080, 16'h0303, 16'h0304, 16'h0400, 16'h0303};
    logic [3:0] f [6] = '{4'h2, 4'hb, 4'h5, 4'h4, 4'h7, 4'h8};
    for (int i = 0; i < 6; i++)
    begin
      @(posedge i_mclk) {i_port80_en, i_win_en} <= f[i][3:2];
      set_init(24'h000010 + i);
      host.access(ad[i], f[i][1]);
      #1 chk("strobe", {23'h0, f[i][0]}, {23'h0, o_tcv === 24'h000010 + i});
    end
    $display("test strobes done");
  endtask : test_strobes
  task stop_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (20) @(posedge i_mclk);
    i_rst_n <= 1;
    @(posedge i_mclk) #1 chk("count", 24'hffffff, o_tcv);
    chk("period", 24'hffffff, o_iv);
    test_expiry;
    test_strobes;
    stop_test;
  end
  initial
  begin
    #1000000 n_fail++;
    stop_test;
  end
endmodule : tb_bwdt_top
`default_nettype wire
